/* hw/smm_pkg.sv */
// Constants and types for the memory-write command and monitor block.
// Assumes one 50 MHz clock; all users write smm_pkg::name, nothing is imported.
package smm_pkg;

    // =====================================================================
    // Register map (byte offsets on the plain register port)
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_MON_SEL   = 8'h04;
    localparam logic [7:0] OFS_OPT_ONE   = 8'h08;
    localparam logic [7:0] OFS_OPT_TWO   = 8'h0c;
    localparam logic [7:0] OFS_CORR_SEL  = 8'h10;
    localparam logic [7:0] OFS_CMN_ONE   = 8'h14;
    localparam logic [7:0] OFS_CMN_TWO   = 8'h18;
    localparam logic [7:0] OFS_POSITIONING_DONE_BIT_W    = 8'h1c;
    localparam logic [7:0] OFS_NEAR_W    = 8'h20;
    localparam logic [7:0] OFS_STATUS    = 8'h24;

    // =====================================================================
    // Field positions
    localparam int MODE_LSB      = 4;
    localparam int TYPE_LSB      = 0;
    localparam int SEL_TWO_LSB   = 4;
    localparam int CORR_DIG_LSB  = 8;
    localparam int ST_WARN_LSB   = 0;
    localparam int ST_DISP_LSB   = 4;
    localparam int ST_DEN        = 6;
    localparam int ST_POSITIONING_DONE_BIT       = 7;
    localparam int ST_NEAR       = 8;
    localparam int ST_BUSY       = 9;

    // =====================================================================
    // Command encodings
    localparam logic [3:0] MODE_VOL     = 4'h1;
    localparam logic [3:0] MODE_NV      = 4'h2;
    localparam logic [3:0] TYPE_BYTE    = 4'h1;
    localparam logic [3:0] TYPE_SHORT   = 4'h2;
    localparam logic [3:0] TYPE_LONG    = 4'h3;
    localparam logic [3:0] WARN_NONE    = 4'h0;
    localparam logic [3:0] WARN_MEM     = 4'h9;
    localparam logic [17:0] MAX_FRAME_BYTES = 18'h00018;

    // =====================================================================
    // Address areas
    localparam logic [31:0] COMMON_BASE = 32'h0000_0000;
    localparam logic [31:0] COMMON_LAST = 32'h0000_0fff;
    localparam logic [31:0] COMMON_RSV0 = 32'h0000_0800;
    localparam logic [31:0] COMMON_RSV1 = 32'h0000_08ff;
    localparam logic [31:0] VENDOR_BASE = 32'h0000_1000;
    localparam logic [31:0] VENDOR_LAST = 32'h0000_7fff;
    localparam logic [31:0] VENDOR_RSV0 = 32'h0000_6000;
    localparam logic [31:0] VENDOR_RSV1 = 32'h0000_6fff;

    // =====================================================================
    // Monitor selection codes
    localparam logic [3:0]  SEL_FEEDBACK  = 4'h0;
    localparam logic [3:0]  SEL_FILT_CMD  = 4'h1;
    localparam logic [3:0]  SEL_POS_ERR   = 4'h2;
    localparam logic [3:0]  SEL_LATCH_ONE = 4'h3;
    localparam logic [3:0]  SEL_LATCH_TWO = 4'h4;
    localparam logic [3:0]  SEL_DELAYED   = 4'h9;
    localparam logic [3:0]  SEL_CMN_ONE   = 4'hc;
    localparam logic [3:0]  SEL_CMN_TWO   = 4'hd;
    localparam logic [3:0]  SEL_OMN_ONE   = 4'he;
    localparam logic [3:0]  SEL_OMN_TWO   = 4'hf;
    localparam logic [15:0] OPT_CORR      = 16'h004d;
    localparam logic [15:0] OPT_LAST_ONE  = 16'h0080;
    localparam logic [15:0] OPT_LAST_TWO  = 16'h0081;
    localparam logic [15:0] CMN_TARGET    = 16'h0000;
    localparam logic [15:0] CMN_UNFILT    = 16'h0001;
    localparam logic [3:0]  CORR_AFTER    = 4'h1;

    // =====================================================================
    // Reset values
    localparam logic [7:0]  RST_MON_SEL = 8'h00;
    localparam logic [15:0] RST_SEL16   = 16'h0000;
    localparam logic [31:0] RST_POSITIONING_DONE_BIT_W  = 32'h0000_0007;
    localparam logic [31:0] RST_NEAR_W  = 32'h0000_0010;

    // =====================================================================
    // Types
    typedef enum logic [1:0] {SMM_DISP_NONE, SMM_DISP_ADDR, SMM_DISP_PARAM,
                              SMM_DISP_SIZE} smm_disp_t;
    typedef enum logic [1:0] {SMM_IDLE, SMM_DATA, SMM_COMMIT, SMM_STEP} smm_st_t;

    typedef struct packed {
        smm_st_t     st;
        logic        follower;
        logic [7:0]  monSel;
        logic [15:0] optOne;
        logic [15:0] optTwo;
        logic [15:0] corrSel;
        logic [15:0] cmnOne;
        logic [15:0] cmnTwo;
        logic [31:0] psetW;
        logic [31:0] nearW;
        logic [31:0] rdData;
        logic [31:0] curAddr;
        logic [15:0] remain;
        logic [2:0]  elemBytes;
        logic        nvMode;
        logic        direct;
        logic [31:0] word;
        logic        memWr;
        logic        memNv;
        logic [31:0] memAddr;
        logic [31:0] memData;
        logic [2:0]  memBytes;
        logic        dataReady;
        logic        busy;
        logic        cmdDone;
        logic [3:0]  warn;
        smm_disp_t   disp;
        logic [31:0] monOne;
        logic [31:0] monTwo;
        logic [31:0] corrMon;
        logic        distDone;
        logic        posDone;
        logic        near;
    } smm_state_t;

endpackage

/* hw/smm_memwrite_monitor.sv */
// Memory-write command checker and writer, plus monitor slot and status bits.
// Assumes synchronous inputs on sys_clk and one command at a time from the link.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps

module smm_memwrite_monitor (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    // Memory-write command
    input  wire logic        cmdValid,
    input  wire logic [7:0]  cmdModeType,
    input  wire logic [15:0] cmdSize,
    input  wire logic [31:0] cmdAddress,
    input  wire logic        dataValid,
    input  wire logic [31:0] dataWord,
    output logic             dataReady,
    output logic             cmdBusy,
    output logic             cmdDone,
    output logic      [3:0]  commandWarningField,
    output logic      [1:0]  warningDisplay,
    // Storage write port
    output logic             memWrEn,
    output logic             memWrNv,
    output logic      [31:0] memWrAddr,
    output logic      [31:0] memWrData,
    output logic      [2:0]  memWrBytes,
    // Position quantities
    input  wire logic [31:0] feedbackPosition,
    input  wire logic [31:0] filteredCommandPosition,
    input  wire logic [31:0] positionError,
    input  wire logic [31:0] latchedPositionOne,
    input  wire logic [31:0] latchedPositionTwo,
    input  wire logic [31:0] delayedCommandPosition,
    input  wire logic [31:0] targetPosition,
    input  wire logic [31:0] unfilteredCommandPosition,
    input  wire logic [31:0] lastLatchOne,
    input  wire logic [31:0] lastLatchTwo,
    input  wire logic [31:0] correctionTableOut,
    input  wire logic        distributionFinished,
    // Monitor and status outputs
    output logic      [31:0] monitorSlotOne,
    output logic      [31:0] monitorSlotTwo,
    output logic      [31:0] correctionAmountMonitor,
    output logic             distributionDoneBit,
    output logic             positioningDoneBit,
    output logic             nearBit
);

    // =====================================================================
    // Decode helpers
    function automatic logic [2:0] elemSize(input logic [3:0] t);
        unique case (t)
            smm_pkg::TYPE_BYTE:  elemSize = 3'h1;
            smm_pkg::TYPE_SHORT: elemSize = 3'h2;
            smm_pkg::TYPE_LONG:  elemSize = 3'h4;
            default:             elemSize = 3'h0;
        endcase
    endfunction

    function automatic logic inCommon(input logic [31:0] a);
        inCommon = (a >= smm_pkg::COMMON_BASE) && (a <= smm_pkg::COMMON_LAST);
    endfunction

    function automatic logic inVendor(input logic [31:0] a);
        inVendor = (a >= smm_pkg::VENDOR_BASE) && (a <= smm_pkg::VENDOR_LAST);
    endfunction

    function automatic logic [31:0] optPick(input logic [15:0] s,
                                            input logic [31:0] corr,
                                            input logic [31:0] l1,
                                            input logic [31:0] l2);
        if (s == smm_pkg::OPT_CORR)
            optPick = corr;
        else if (s == smm_pkg::OPT_LAST_ONE)
            optPick = l1;
        else if (s == smm_pkg::OPT_LAST_TWO)
            optPick = l2;
        else
            optPick = 32'h0000_0000;
    endfunction

    // =====================================================================
    // State
    smm_pkg::smm_state_t r_r;
    smm_pkg::smm_state_t r_nxt;

    // Command checks
    logic [3:0]  cmdMode;
    logic [3:0]  cmdType;
    logic [2:0]  cmdBytes;
    logic [17:0] lenBytes;
    logic [32:0] lastAddr;
    logic        paramBad;
    logic        addrBad;
    logic        sizeBad;
    logic        areaCommon;

    // Monitor values
    logic [31:0] corrAmt;
    logic [31:0] corrAdd;
    logic [31:0] optOneVal;
    logic [31:0] optTwoVal;
    logic [32:0] devDiff;
    logic [31:0] devAbs;

    always_comb begin
        cmdMode    = cmdModeType[smm_pkg::MODE_LSB +: 4];
        cmdType    = cmdModeType[smm_pkg::TYPE_LSB +: 4];
        cmdBytes   = elemSize(cmdType);
        lenBytes   = 18'(cmdSize) * 18'(cmdBytes);
        lastAddr   = 33'(cmdAddress) + 33'(lenBytes) - 33'h1;
        areaCommon = inCommon(cmdAddress);
        paramBad   = ((cmdMode != smm_pkg::MODE_VOL) && (cmdMode != smm_pkg::MODE_NV))
                     || (cmdBytes == 3'h0);
        addrBad    = !(areaCommon || inVendor(cmdAddress))
                     || ((cmdAddress >= smm_pkg::COMMON_RSV0)
                         && (cmdAddress <= smm_pkg::COMMON_RSV1))
                     || ((cmdAddress >= smm_pkg::VENDOR_RSV0)
                         && (cmdAddress <= smm_pkg::VENDOR_RSV1))
                     || ((cmdBytes == 3'h2) && cmdAddress[0])
                     || ((cmdBytes == 3'h4) && (cmdAddress[1:0] != 2'h0));
        sizeBad    = (lenBytes > smm_pkg::MAX_FRAME_BYTES)
                     || (areaCommon && (cmdSize != 16'h0)
                         && (lastAddr > 33'(smm_pkg::COMMON_LAST)))
                     || (!areaCommon && (cmdSize != 16'h0)
                         && (lastAddr > 33'(smm_pkg::VENDOR_LAST)));
    end

    // Master axis always reads zero correction
    always_comb begin
        corrAmt   = r_r.follower ? correctionTableOut : 32'h0000_0000;
        corrAdd   = (r_r.corrSel[smm_pkg::CORR_DIG_LSB +: 4] == smm_pkg::CORR_AFTER)
                    ? corrAmt : 32'h0000_0000;
        optOneVal = optPick(r_r.optOne, corrAmt, lastLatchOne, lastLatchTwo);
        optTwoVal = optPick(r_r.optTwo, corrAmt, lastLatchOne, lastLatchTwo);
        // Correction cancels in the difference, kept literal for clarity
        devDiff   = 33'(signed'(targetPosition + corrAmt))
                    - 33'(signed'(feedbackPosition + corrAmt));
        devAbs    = devDiff[32] ? 32'(-devDiff) : devDiff[31:0];
    end

    // One selector per monitor slot
    for (genvar g = 0; g < 2; g++) begin : gSlot
        logic [3:0]  sel;
        logic [15:0] cfg;
        logic [31:0] val;
        always_comb begin
            sel = r_r.monSel[g*smm_pkg::SEL_TWO_LSB +: 4];
            cfg = (sel == smm_pkg::SEL_CMN_TWO) ? r_r.cmnTwo : r_r.cmnOne;
            unique case (sel)
                smm_pkg::SEL_FEEDBACK:  val = feedbackPosition + corrAdd;
                smm_pkg::SEL_FILT_CMD:  val = filteredCommandPosition + corrAdd;
                smm_pkg::SEL_POS_ERR:   val = positionError;
                smm_pkg::SEL_LATCH_ONE: val = latchedPositionOne + corrAdd;
                smm_pkg::SEL_LATCH_TWO: val = latchedPositionTwo + corrAdd;
                smm_pkg::SEL_DELAYED:   val = delayedCommandPosition + corrAdd;
                smm_pkg::SEL_CMN_ONE, smm_pkg::SEL_CMN_TWO: begin
                    if (cfg == smm_pkg::CMN_UNFILT)
                        val = unfilteredCommandPosition + corrAdd;
                    else if (cfg == smm_pkg::CMN_TARGET)
                        val = targetPosition + corrAdd;
                    else
                        val = 32'h0000_0000;
                end
                smm_pkg::SEL_OMN_ONE:   val = optOneVal;
                smm_pkg::SEL_OMN_TWO:   val = optTwoVal;
                default:                val = 32'h0000_0000;
            endcase
        end
    end

    // =====================================================================
    // Next state
    always_comb begin
        r_nxt          = r_r;
        r_nxt.memWr    = 1'b0;
        r_nxt.cmdDone  = 1'b0;
        r_nxt.rdData   = 32'h0000_0000;

        // Register writes
        if (regWr) begin
            unique case (regAddr)
                smm_pkg::OFS_CTRL:     r_nxt.follower = regWrData[0];
                smm_pkg::OFS_MON_SEL:  r_nxt.monSel   = regWrData[7:0];
                smm_pkg::OFS_OPT_ONE:  r_nxt.optOne   = regWrData[15:0];
                smm_pkg::OFS_OPT_TWO:  r_nxt.optTwo   = regWrData[15:0];
                smm_pkg::OFS_CORR_SEL: r_nxt.corrSel  = regWrData[15:0];
                smm_pkg::OFS_CMN_ONE:  r_nxt.cmnOne   = regWrData[15:0];
                smm_pkg::OFS_CMN_TWO:  r_nxt.cmnTwo   = regWrData[15:0];
                smm_pkg::OFS_POSITIONING_DONE_BIT_W:   r_nxt.psetW    = regWrData;
                smm_pkg::OFS_NEAR_W:   r_nxt.nearW    = regWrData;
                default:               ;
            endcase
        end

        // Register reads, data valid the next cycle only
        if (regRd) begin
            unique case (regAddr)
                smm_pkg::OFS_CTRL:     r_nxt.rdData = {31'h0, r_r.follower};
                smm_pkg::OFS_MON_SEL:  r_nxt.rdData = {24'h0, r_r.monSel};
                smm_pkg::OFS_OPT_ONE:  r_nxt.rdData = {16'h0, r_r.optOne};
                smm_pkg::OFS_OPT_TWO:  r_nxt.rdData = {16'h0, r_r.optTwo};
                smm_pkg::OFS_CORR_SEL: r_nxt.rdData = {16'h0, r_r.corrSel};
                smm_pkg::OFS_CMN_ONE:  r_nxt.rdData = {16'h0, r_r.cmnOne};
                smm_pkg::OFS_CMN_TWO:  r_nxt.rdData = {16'h0, r_r.cmnTwo};
                smm_pkg::OFS_POSITIONING_DONE_BIT_W:   r_nxt.rdData = r_r.psetW;
                smm_pkg::OFS_NEAR_W:   r_nxt.rdData = r_r.nearW;
                smm_pkg::OFS_STATUS: begin
                    r_nxt.rdData[smm_pkg::ST_WARN_LSB +: 4] = r_r.warn;
                    r_nxt.rdData[smm_pkg::ST_DISP_LSB +: 2] = r_r.disp;
                    r_nxt.rdData[smm_pkg::ST_DEN]           = r_r.distDone;
                    r_nxt.rdData[smm_pkg::ST_POSITIONING_DONE_BIT]          = r_r.posDone;
                    r_nxt.rdData[smm_pkg::ST_NEAR]          = r_r.near;
                    r_nxt.rdData[smm_pkg::ST_BUSY]          = r_r.busy;
                end
                default:               r_nxt.rdData = 32'h0000_0000;
            endcase
        end

        // Command sequencer
        unique case (r_r.st)
            smm_pkg::SMM_IDLE: begin
                if (cmdValid) begin
                    r_nxt.curAddr   = cmdAddress;
                    r_nxt.remain    = cmdSize;
                    r_nxt.elemBytes = cmdBytes;
                    r_nxt.nvMode    = (cmdMode == smm_pkg::MODE_NV);
                    r_nxt.direct    = areaCommon;
                    // Checks ranked parameter, address, size; fail writes nothing
                    if (paramBad) begin
                        r_nxt.warn    = smm_pkg::WARN_MEM;
                        r_nxt.disp    = smm_pkg::SMM_DISP_PARAM;
                        r_nxt.cmdDone = 1'b1;
                    end else if (addrBad) begin
                        r_nxt.warn    = smm_pkg::WARN_MEM;
                        r_nxt.disp    = smm_pkg::SMM_DISP_ADDR;
                        r_nxt.cmdDone = 1'b1;
                    end else if (sizeBad) begin
                        r_nxt.warn    = smm_pkg::WARN_MEM;
                        r_nxt.disp    = smm_pkg::SMM_DISP_SIZE;
                        r_nxt.cmdDone = 1'b1;
                    end else begin
                        r_nxt.warn = smm_pkg::WARN_NONE;
                        r_nxt.disp = smm_pkg::SMM_DISP_NONE;
                        if (cmdSize == 16'h0) begin
                            r_nxt.cmdDone = 1'b1;
                        end else begin
                            r_nxt.st        = smm_pkg::SMM_DATA;
                            r_nxt.busy      = 1'b1;
                            r_nxt.dataReady = 1'b1;
                        end
                    end
                end
            end
            smm_pkg::SMM_DATA: begin
                if (dataValid && r_r.dataReady) begin
                    r_nxt.dataReady = 1'b0;
                    r_nxt.word      = dataWord;
                    r_nxt.memWr     = 1'b1;
                    r_nxt.memAddr   = r_r.curAddr;
                    r_nxt.memData   = dataWord;
                    r_nxt.memBytes  = r_r.elemBytes;
                    // Direct only for common area; else volatile copy first
                    r_nxt.memNv     = r_r.nvMode && r_r.direct;
                    r_nxt.st        = (r_r.nvMode && !r_r.direct)
                                      ? smm_pkg::SMM_COMMIT : smm_pkg::SMM_STEP;
                end
            end
            smm_pkg::SMM_COMMIT: begin
                r_nxt.memWr = 1'b1;
                r_nxt.memNv = 1'b1;
                r_nxt.st    = smm_pkg::SMM_STEP;
            end
            smm_pkg::SMM_STEP: begin
                r_nxt.curAddr = r_r.curAddr + 32'(r_r.elemBytes);
                r_nxt.remain  = r_r.remain - 16'h1;
                if (r_r.remain == 16'h1) begin
                    r_nxt.st      = smm_pkg::SMM_IDLE;
                    r_nxt.busy    = 1'b0;
                    r_nxt.cmdDone = 1'b1;
                end else begin
                    r_nxt.st        = smm_pkg::SMM_DATA;
                    r_nxt.dataReady = 1'b1;
                end
            end
        endcase

        // Monitors and status bits
        r_nxt.monOne   = gSlot[0].val;
        r_nxt.monTwo   = gSlot[1].val;
        r_nxt.corrMon  = corrAmt;
        r_nxt.distDone = distributionFinished;
        r_nxt.posDone  = distributionFinished && (devAbs <= r_r.psetW);
        r_nxt.near     = (devAbs <= r_r.nearW);

        if (sys_rst) begin
            r_nxt         = '0;
            r_nxt.st      = smm_pkg::SMM_IDLE;
            r_nxt.disp    = smm_pkg::SMM_DISP_NONE;
            r_nxt.monSel  = smm_pkg::RST_MON_SEL;
            r_nxt.optOne  = smm_pkg::RST_SEL16;
            r_nxt.optTwo  = smm_pkg::RST_SEL16;
            r_nxt.corrSel = smm_pkg::RST_SEL16;
            r_nxt.cmnOne  = smm_pkg::RST_SEL16;
            r_nxt.cmnTwo  = smm_pkg::RST_SEL16;
            r_nxt.psetW   = smm_pkg::RST_POSITIONING_DONE_BIT_W;
            r_nxt.nearW   = smm_pkg::RST_NEAR_W;
        end
    end

    always_ff @(posedge sys_clk) begin
        r_r <= r_nxt;
    end

    // =====================================================================
    // Outputs, all straight from the state register
    assign regRdData               = r_r.rdData;
    assign dataReady               = r_r.dataReady;
    assign cmdBusy                 = r_r.busy;
    assign cmdDone                 = r_r.cmdDone;
    assign commandWarningField     = r_r.warn;
    assign warningDisplay          = r_r.disp;
    assign memWrEn                 = r_r.memWr;
    assign memWrNv                 = r_r.memNv;
    assign memWrAddr               = r_r.memAddr;
    assign memWrData               = r_r.memData;
    assign memWrBytes              = r_r.memBytes;
    assign monitorSlotOne          = r_r.monOne;
    assign monitorSlotTwo          = r_r.monTwo;
    assign correctionAmountMonitor = r_r.corrMon;
    assign distributionDoneBit     = r_r.distDone;
    assign positioningDoneBit      = r_r.posDone;
    assign nearBit                 = r_r.near;

endmodule // smm_memwrite_monitor

/* verif/smm_host_model.sv */
// Host side data source for memory-write beats.
// Assumes beats are taken only while the block asserts dataReady.
`timescale 1ns/100ps
module smm_host_model (
    input  wire logic        sys_clk,
    input  wire logic        slow,
    input  wire logic        dataReady,
    output logic             dataValid,
    output logic      [31:0] dataWord
);
    // Counting words make every beat traceable; idle line shows the inverse
    logic [31:0] cnt = 32'h0000_a000;
    logic        stall = 1'b0;
    assign dataValid = !stall;
    assign dataWord  = dataValid ? cnt : ~cnt;
    always @(posedge sys_clk) begin
        stall <= slow && (dataValid ? dataReady : !dataReady);
        if (dataValid && dataReady) cnt <= cnt + 32'h1;
    end
endmodule // smm_host_model

/* verif/smm_props.sv */
// Port checks of the memory-write and monitor block.
// Assumes one clock domain; bound to the design below.
`timescale 1ns/100ps
module smm_props (
    // Clock, reset, command
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        cmdValid,
    input wire logic [7:0]  cmdModeType,
    input wire logic [15:0] cmdSize,
    input wire logic [31:0] cmdAddress,
    input wire logic        cmdBusy,
    input wire logic        cmdDone,
    input wire logic [3:0]  commandWarningField,
    input wire logic [1:0]  warningDisplay,
    // Data, storage, status
    input wire logic        dataValid,
    input wire logic        dataReady,
    input wire logic        memWrEn,
    input wire logic        distributionFinished,
    input wire logic        distributionDoneBit,
    input wire logic        positioningDoneBit
);
    // ==========
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_take; cmdValid && !cmdBusy; endsequence
    sequence s_long; s_take ##0 cmdModeType == 8'h13; endsequence
    property p_code; warningDisplay != 2'd0 |-> commandWarningField == 4'h9; endproperty
    a_code: assert property (p_code) else $error("bad code");
    property p_param; s_take ##0 cmdModeType[3:0] == 4'h4 |=> warningDisplay == 2'd2; endproperty
    a_param: assert property (p_param) else $error("bad param");
    property p_align; s_long ##0 cmdAddress[1:0] != 2'd0 |=> warningDisplay == 2'd1; endproperty
    a_align: assert property (p_align) else $error("bad align");
    property p_frame; s_long ##0 cmdSize > 16'd6 && cmdAddress == 32'h1000
        |=> warningDisplay == 2'd3; endproperty
    a_frame: assert property (p_frame) else $error("bad frame");
    property p_beat; dataValid && dataReady |=> memWrEn; endproperty
    a_beat: assert property (p_beat) else $error("beat lost");
    property p_clean; cmdDone && warningDisplay != 2'd0 |-> !memWrEn [*2]; endproperty
    a_clean: assert property (p_clean) else $error("write on fail");
    property p_den; !$past(sys_rst) |-> distributionDoneBit == $past(distributionFinished); endproperty
    a_den: assert property (p_den) else $error("bad den");
    property p_positioning_done_bit; positioningDoneBit |-> distributionDoneBit; endproperty
    a_positioning_done_bit: assert property (p_positioning_done_bit) else $error("bad positioning_done_bit");
endmodule // smm_props
bind smm_memwrite_monitor smm_props chk_u (.*);

/* verif/servo_memwrite_and_monitor_test.sv */
// Self-checking bench of the memory-write and monitor block.
// Assumes the host model feeds data beats.
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %h seen %h", n, e, s); end end
module servo_memwrite_and_monitor_test;
    // ==========
    // Ports
    logic sys_clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, cmdValid = 1'b0;
    logic slow = 1'b0, distributionFinished = 1'b0, dataValid, dataReady, cmdBusy, cmdDone;
    logic memWrEn, memWrNv, distributionDoneBit, positioningDoneBit, nearBit;
    logic [7:0] regAddr = 8'h00, cmdModeType = 8'h00;
    logic [15:0] cmdSize = 16'h0000;
    logic [31:0] regWrData = 32'h0, cmdAddress = 32'h0, feedbackPosition = 32'h10;
    logic [31:0] filteredCommandPosition = 32'h11, positionError = 32'h12, lastAddr;
    logic [31:0] latchedPositionOne = 32'h13, latchedPositionTwo = 32'h14, lastLatchTwo = 32'h1f;
    logic [31:0] delayedCommandPosition = 32'h19, targetPosition = 32'h15, lastLatchOne = 32'h1e;
    logic [31:0] unfilteredCommandPosition = 32'h1c, correctionTableOut = 32'hffff_fffb;
    logic [31:0] regRdData, dataWord, memWrAddr, memWrData;
    logic [31:0] monitorSlotOne, monitorSlotTwo, correctionAmountMonitor;
    logic [3:0] commandWarningField;
    logic [2:0] memWrBytes;
    logic [1:0] warningDisplay;
    int fail_count = 0, checked = 0, cycles = 0, writes = 0, nv = 0, i;
    logic [3:0] sc[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9};
    logic [31:0] ev[6] = '{32'h10, 32'h11, 32'h12, 32'h13, 32'h14, 32'h19};
    smm_memwrite_monitor dut_u (.*);
    smm_host_model host_u (.*);
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (memWrEn) begin writes++; lastAddr = memWrAddr; nv += memWrNv; end
        if (cycles == 4000) begin fail_count++; tally_and_finish(); end
    end
    task tally_and_finish;
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) begin regWr <= 1'b1; regAddr <= a; regWrData <= d; end
        @(posedge sys_clk) regWr <= 1'b0;
    endtask
    task settle; repeat (2) @(posedge sys_clk); #1; endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk) begin regRd <= 1'b1; regAddr <= a; end
        @(posedge sys_clk) regRd <= 1'b0;
        #1 `CHK("rdata", e, regRdData)
    endtask
    task cmd(input logic [7:0] mt, input logic [15:0] sz, input logic [31:0] ad,
             input logic [1:0] ed);
        int n;
        n = 0;
        @(posedge sys_clk) begin cmdValid <= 1'b1; cmdModeType <= mt; cmdSize <= sz; end
        cmdAddress <= ad;
        @(posedge sys_clk) cmdValid <= 1'b0;
        #1 while (cmdDone !== 1'b1 && n++ < 200) @(posedge sys_clk) #1;
        `CHK("disp", ed, warningDisplay)
        `CHK("warn", (ed != 2'd0) ? 4'h9 : 4'h0, commandWarningField)
    endtask
    task t_reject;
        rd(8'h1c, 32'h7);
        rd(8'h20, 32'h10);
        rd(8'h44, 32'h0);
        cmd(8'h03, 16'h1, 32'h10, 2'd2);
        cmd(8'h14, 16'h1, 32'h10, 2'd2);
        cmd(8'h11, 16'h1, 32'h8000, 2'd1);
        cmd(8'h11, 16'h1, 32'h0800, 2'd1);
        cmd(8'h11, 16'h1, 32'h6000, 2'd1);
        cmd(8'h13, 16'h1, 32'h1002, 2'd1);
        cmd(8'h13, 16'h2, 32'h7ffc, 2'd3);
        cmd(8'h13, 16'h7, 32'h1000, 2'd3);
        rd(8'h24, 32'h139);
        `CHK("nowrite", 0, writes)
    endtask
    task t_write;
        slow <= 1'b1;
        cmd(8'h23, 16'h2, 32'h1000, 2'd0);
        `CHK("commits", 4, writes)
        `CHK("nv", 2, nv)
        `CHK("addr", 32'h1004, lastAddr)
        writes = 0;
        cmd(8'h22, 16'h1, 32'h0100, 2'd0);
        `CHK("direct", 1, writes)
        writes = 0;
        cmd(8'h11, 16'h3, 32'h0020, 2'd0);
        `CHK("bytes", 3, writes)
        `CHK("addr", 32'h22, lastAddr)
        `CHK("nv", 3, nv)
    endtask
    task t_mon;
        wr(8'h00, 32'h1); settle;
        `CHK("corr", 32'hffff_fffb, correctionAmountMonitor)
        wr(8'h00, 32'h0); settle;
        `CHK("corr", 32'h0, correctionAmountMonitor)
        for (i = 0; i < 6; i++) begin
            wr(8'h04, {24'h0, sc[i], sc[i]}); settle;
            `CHK("slot", ev[i], monitorSlotTwo)
        end
        wr(8'h18, 32'h1); wr(8'h04, 32'hdc); settle;
        `CHK("target", 32'h15, monitorSlotOne)
        `CHK("unfilt", 32'h1c, monitorSlotTwo)
        wr(8'h00, 32'h1); wr(8'h08, 32'h4d); wr(8'h0c, 32'h81); wr(8'h04, 32'hfe); settle;
        `CHK("optcorr", 32'hffff_fffb, monitorSlotOne)
        `CHK("latch2", 32'h1f, monitorSlotTwo)
        wr(8'h10, 32'h100); wr(8'h04, 32'h0); settle;
        `CHK("after", 32'hb, monitorSlotOne)
        @(posedge sys_clk) distributionFinished <= 1'b1; settle;
        `CHK("positioning_done_bit", 1'b1, positioningDoneBit)
        @(posedge sys_clk) feedbackPosition <= 32'h5; settle;
        `CHK("far", 1'b0, positioningDoneBit)
        `CHK("near", 1'b1, nearBit)
        `CHK("den", 1'b1, distributionDoneBit)
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reject;
        t_write;
        t_mon;
        tally_and_finish();
    end
endmodule // servo_memwrite_and_monitor_test
